// file: include/rwa_pkg.sv
// Package: constants and types for the working-register ALU datapath
package rwa_pkg;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 14;
    localparam int NIB_W = 4;
    localparam int PHASES = 4;
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q4 = 2'h3;
    localparam logic [7:0] W_RESET = 8'h00;
    // Flag positions on the status write ports
    localparam int STAT_C = 0;
    localparam int STAT_NC = 1;
    localparam int STAT_Z = 2;
    // Input clock figures and the derived instruction cycle
    localparam int IN_CLK_MHZ = 20;
    localparam int CYCLE_NS = 200;
    localparam int CYCLE_CLKS = CYCLE_NS * IN_CLK_MHZ / 1000;
    // Operation selects driven by the decoder
    typedef enum logic [3:0] {
        RWA_OP_PASS_A, RWA_OP_PASS_B, RWA_OP_ADD, RWA_OP_SUB, RWA_OP_AND,
        RWA_OP_IOR, RWA_OP_XOR, RWA_OP_COM, RWA_OP_INC, RWA_OP_DEC,
        RWA_OP_RLF, RWA_OP_RRF, RWA_OP_SWAP, RWA_OP_CLR
    } rwa_op_t;
    typedef enum logic {
        RWA_SRC_FILE, RWA_SRC_IMM
    } rwa_src_t;
endpackage

// file: logic/rwa_datapath.sv
// ALU datapath with working register, flags and quarter-rate phase counter
`timescale 1ns/10ps
`default_nettype none
module rwa_datapath #(
    parameter int DATA_W = rwa_pkg::DATA_W,
    parameter int INSTR_W = rwa_pkg::INSTR_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Program bus
    input wire logic [INSTR_W-1:0] prog_data_i,
    output logic fetch_o,
    output logic [INSTR_W-1:0] instr_o,
    output logic instr_valid_o,
    // Decoder controls
    input wire logic exec_i,
    input wire rwa_pkg::rwa_op_t op_i,
    input wire rwa_pkg::rwa_src_t src_i,
    input wire logic [DATA_W-1:0] imm_i,
    input wire logic to_file_i,
    input wire logic upd_c_i,
    input wire logic upd_nc_i,
    input wire logic upd_z_i,
    input wire logic branch_i,
    // Data-memory bus
    input wire logic [DATA_W-1:0] file_rdata_i,
    input wire logic [2:0] status_wr_i,
    input wire logic [2:0] status_wdata_i,
    output logic [DATA_W-1:0] file_wdata_o,
    output logic file_we_o,
    // State
    output logic [DATA_W-1:0] w_o,
    output logic carry_flag_o,
    output logic nibble_carry_flag_o,
    output logic zero_flag_o,
    output logic phase_q1_o
);
    logic [1:0] phase_reg;
    logic [INSTR_W-1:0] instr_reg;
    logic valid_reg;
    logic [DATA_W-1:0] w_reg;
    logic [DATA_W-1:0] res_reg;
    logic we_reg;
    logic c_reg;
    logic nc_reg;
    logic z_reg;
    wire logic q1 = (phase_reg == rwa_pkg::PH_Q1);
    wire logic q4 = (phase_reg == rwa_pkg::PH_Q4);
    wire logic do_exec = q4 && exec_i && valid_reg;
    // Operand selection
    wire logic [DATA_W-1:0] opa = w_reg;
    wire logic [DATA_W-1:0] opb = (src_i == rwa_pkg::RWA_SRC_IMM) ? imm_i : file_rdata_i;
    wire logic [DATA_W-1:0] ones = '1;
    wire logic [DATA_W-1:0] one = DATA_W'(1);
    wire logic [DATA_W:0] add_s = {1'b0, opb} + {1'b0, opa};
    wire logic [DATA_W:0] sub_s = {1'b0, opb} + {1'b0, ~opa} + {{DATA_W{1'b0}}, 1'b1};
    wire logic [rwa_pkg::NIB_W:0] add_n =
        {1'b0, opb[rwa_pkg::NIB_W-1:0]} + {1'b0, opa[rwa_pkg::NIB_W-1:0]};
    wire logic [rwa_pkg::NIB_W:0] sub_n = {1'b0, opb[rwa_pkg::NIB_W-1:0]} +
        {1'b0, ~opa[rwa_pkg::NIB_W-1:0]} + {{rwa_pkg::NIB_W{1'b0}}, 1'b1};
    logic [DATA_W-1:0] res;
    logic c_new;
    logic nc_new;
    always_comb begin
        res = opb;
        c_new = c_reg;
        nc_new = nc_reg;
        unique case (op_i)
            rwa_pkg::RWA_OP_PASS_A: res = opa;
            rwa_pkg::RWA_OP_PASS_B: res = opb;
            rwa_pkg::RWA_OP_ADD: begin
                res = add_s[DATA_W-1:0];
                c_new = add_s[DATA_W];
                nc_new = add_n[rwa_pkg::NIB_W];
            end
            rwa_pkg::RWA_OP_SUB: begin
                res = sub_s[DATA_W-1:0];
                c_new = sub_s[DATA_W];
                nc_new = sub_n[rwa_pkg::NIB_W];
            end
            rwa_pkg::RWA_OP_AND: res = opa & opb;
            rwa_pkg::RWA_OP_IOR: res = opa | opb;
            rwa_pkg::RWA_OP_XOR: res = opa ^ opb;
            rwa_pkg::RWA_OP_COM: res = opb ^ ones;
            rwa_pkg::RWA_OP_INC: res = opb + one;
            rwa_pkg::RWA_OP_DEC: res = opb - one;
            rwa_pkg::RWA_OP_RLF: begin
                res = {opb[DATA_W-2:0], c_reg};
                c_new = opb[DATA_W-1];
            end
            rwa_pkg::RWA_OP_RRF: begin
                res = {c_reg, opb[DATA_W-1:1]};
                c_new = opb[0];
            end
            rwa_pkg::RWA_OP_SWAP: res = {opb[rwa_pkg::NIB_W-1:0], opb[DATA_W-1:rwa_pkg::NIB_W]};
            rwa_pkg::RWA_OP_CLR: res = '0;
            default: res = opb;
        endcase
    end
    wire logic z_new = (res == '0);
    // Phase counter: one instruction cycle is four clocks
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            phase_reg <= rwa_pkg::PH_Q1;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end
    // Instruction latch, flushed after a branch
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            instr_reg <= '0;
            valid_reg <= 1'b0;
        end else if (q4) begin
            instr_reg <= prog_data_i;
            valid_reg <= !(do_exec && branch_i);
        end
    end
    // Working register and result
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            w_reg <= rwa_pkg::W_RESET;
            res_reg <= '0;
            we_reg <= 1'b0;
        end else begin
            we_reg <= do_exec && to_file_i;
            if (do_exec) begin
                res_reg <= res;
                if (!to_file_i) begin
                    w_reg <= res;
                end
            end
        end
    end
    // Status flags; ALU update beats a file write
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            c_reg <= 1'b0;
            nc_reg <= 1'b0;
            z_reg <= 1'b0;
        end else begin
            if (do_exec && upd_c_i) begin
                c_reg <= c_new;
            end else if (status_wr_i[rwa_pkg::STAT_C]) begin
                c_reg <= status_wdata_i[rwa_pkg::STAT_C];
            end
            if (do_exec && upd_nc_i) begin
                nc_reg <= nc_new;
            end else if (status_wr_i[rwa_pkg::STAT_NC]) begin
                nc_reg <= status_wdata_i[rwa_pkg::STAT_NC];
            end
            if (do_exec && upd_z_i) begin
                z_reg <= z_new;
            end else if (status_wr_i[rwa_pkg::STAT_Z]) begin
                z_reg <= status_wdata_i[rwa_pkg::STAT_Z];
            end
        end
    end
    assign fetch_o = q1;
    assign phase_q1_o = q1;
    assign instr_o = instr_reg;
    assign instr_valid_o = valid_reg;
    assign file_wdata_o = res_reg;
    assign file_we_o = we_reg;
    assign w_o = w_reg;
    assign carry_flag_o = c_reg;
    assign nibble_carry_flag_o = nc_reg;
    assign zero_flag_o = z_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_branch;
        do_exec && branch_i;
    endsequence
    sequence s_sw_c;
        status_wr_i[rwa_pkg::STAT_C] && !(do_exec && upd_c_i);
    endsequence
    AST_PHASE_CYCLE: assert property (q1 |-> ##4 q1) else $error("phase not 4");
    AST_FETCH_ONCE: assert property (q1 |-> ##1 !q1 [*3]) else $error("fetch twice");
    AST_BRANCH_FLUSH: assert property (s_branch |=> !instr_valid_o [*4])
        else $error("prefetch not flushed");
    AST_VALID_BACK: assert property (q4 && !(do_exec && branch_i) |=> instr_valid_o)
        else $error("valid not restored");
    AST_LATCH_Q4: assert property (!q4 |=> $stable(instr_o)) else $error("instr off Q4");
    AST_ADD_W: assert property (
        do_exec && !to_file_i && op_i == rwa_pkg::RWA_OP_ADD
        |=> w_o == DATA_W'($past(opb) + $past(opa))) else $error("add wrong");
    AST_SUB_C: assert property (
        do_exec && upd_c_i && op_i == rwa_pkg::RWA_OP_SUB
        |=> carry_flag_o == ($past(opb) >= $past(opa))) else $error("borrow wrong");
    AST_Z_SET: assert property (
        do_exec && upd_z_i |=> zero_flag_o == ($past(res) == '0))
        else $error("zero wrong");
    AST_FLAG_HOLD: assert property (
        !do_exec && status_wr_i == 3'h0
        |=> $stable(carry_flag_o) && $stable(zero_flag_o) && $stable(nibble_carry_flag_o))
        else $error("flag moved");
    AST_FILE_WR: assert property (do_exec && to_file_i |=> file_we_o && $stable(w_o))
        else $error("file write wrong");
    AST_WE_PULSE: assert property (file_we_o |=> !file_we_o) else $error("write too long");
    AST_SW_C: assert property (
        s_sw_c |=> carry_flag_o == $past(status_wdata_i[rwa_pkg::STAT_C]))
        else $error("status write lost");
endmodule
`default_nettype wire

// file: verif/rwa_far_end.sv
// Memory-side model: program memory words and one file register
`timescale 1ns/10ps
`default_nettype none
module rwa_far_end (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Program and data buses
    input wire logic fetch_i,
    input wire logic [7:0] file_wdata_i,
    input wire logic file_we_i,
    output logic [13:0] prog_data_o,
    output logic [7:0] file_rdata_o
);
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            prog_data_o <= 14'h0123;
            file_rdata_o <= 8'h5a;
        end else begin
            if (fetch_i) begin
                prog_data_o <= prog_data_o + 14'h1111;
            end
            if (file_we_i) begin
                file_rdata_o <= file_wdata_i;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/rwa_datapath_bench.sv
// Bench for the working-register ALU datapath
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end
module rwa_datapath_bench;
    logic clk = 1'b0, rst_b = 1'b0, exec = 1'b0, tf = 1'b0, br = 1'b0;
    logic [2:0] upd = 3'h0, swr = 3'h0, swd = 3'h0;
    logic [7:0] imm = 8'h00, fwd, frd, w;
    logic [13:0] pd, instr, word;
    logic fetch, we, c, nc, z, vld, q1o;
    rwa_pkg::rwa_op_t op = rwa_pkg::RWA_OP_PASS_A;
    rwa_pkg::rwa_src_t src = rwa_pkg::RWA_SRC_IMM;
    int num_errors = 0, n_checks = 0, cyc = 0;
    rwa_datapath dut (.ref_clk_i(clk), .rst_b_i(rst_b), .prog_data_i(pd), .fetch_o(fetch),
        .instr_o(instr), .instr_valid_o(vld), .exec_i(exec), .op_i(op), .src_i(src),
        .imm_i(imm), .to_file_i(tf), .upd_c_i(upd[0]), .upd_nc_i(upd[1]),
        .upd_z_i(upd[2]), .branch_i(br), .file_rdata_i(frd), .status_wr_i(swr),
        .status_wdata_i(swd), .file_wdata_o(fwd), .file_we_o(we), .w_o(w),
        .carry_flag_o(c), .nibble_carry_flag_o(nc), .zero_flag_o(z), .phase_q1_o(q1o));
    rwa_far_end far (.clk_i(clk), .rst_b_i(rst_b), .fetch_i(fetch), .file_wdata_i(fwd),
        .file_we_i(we), .prog_data_o(pd), .file_rdata_o(frd));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One instruction in the Q4 slot of the next cycle
    task automatic run(input rwa_pkg::rwa_op_t o, input rwa_pkg::rwa_src_t s,
        input logic [7:0] i, input logic f, input logic [2:0] u, input logic b);
        while (fetch !== 1'b1) @(negedge clk);
        repeat (3) @(negedge clk);
        op = o; src = s; imm = i; tf = f; upd = u; br = b; exec = 1'b1; word = pd;
        @(negedge clk);
        exec = 1'b0; br = 1'b0;
        `CHK(we, f)
        `CHK(instr, word)
    endtask
    task automatic chk(input logic [7:0] ew, input logic ec, enc, ez);
        `CHK({w, c, nc, z}, {ew, ec, enc, ez})
    endtask
    task automatic t_phase();
        int n = 0;
        int m = 0;
        repeat (8) begin
            @(negedge clk);
            n += fetch;
            m += q1o;
        end
        `CHK(n, 2)
        `CHK(m, 2)
    endtask
    task automatic t_arith();
        run(rwa_pkg::RWA_OP_PASS_B, rwa_pkg::RWA_SRC_IMM, 8'h0f, 0, 3'h0, 0);
        run(rwa_pkg::RWA_OP_ADD, rwa_pkg::RWA_SRC_IMM, 8'h01, 0, 3'h7, 0);
        chk(8'h10, 0, 1, 0);
        run(rwa_pkg::RWA_OP_SUB, rwa_pkg::RWA_SRC_IMM, 8'h10, 0, 3'h7, 0);
        chk(8'h00, 1, 1, 1);
        run(rwa_pkg::RWA_OP_PASS_B, rwa_pkg::RWA_SRC_IMM, 8'h01, 0, 3'h0, 0);
        chk(8'h01, 1, 1, 1);
        run(rwa_pkg::RWA_OP_SUB, rwa_pkg::RWA_SRC_IMM, 8'h00, 0, 3'h7, 0);
        chk(8'hff, 0, 0, 0);
    endtask
    task automatic t_file();
        run(rwa_pkg::RWA_OP_XOR, rwa_pkg::RWA_SRC_FILE, 8'h00, 1, 3'h0, 0);
        `CHK(fwd, 8'ha5)
        chk(8'hff, 0, 0, 0);
        run(rwa_pkg::RWA_OP_ADD, rwa_pkg::RWA_SRC_FILE, 8'h00, 0, 3'h7, 0);
        chk(8'ha4, 1, 1, 0);
    endtask
    task automatic t_branch();
        run(rwa_pkg::RWA_OP_PASS_B, rwa_pkg::RWA_SRC_IMM, 8'h33, 0, 3'h0, 1);
        `CHK(vld, 1'b0)
        run(rwa_pkg::RWA_OP_PASS_B, rwa_pkg::RWA_SRC_IMM, 8'h44, 0, 3'h0, 0);
        chk(8'h33, 1, 1, 0);
        `CHK(vld, 1'b1)
        run(rwa_pkg::RWA_OP_PASS_B, rwa_pkg::RWA_SRC_IMM, 8'h55, 0, 3'h0, 0);
        chk(8'h55, 1, 1, 0);
    endtask
    task automatic t_status();
        swr = 3'h7;
        swd = 3'h5;
        @(negedge clk);
        swr = 3'h0;
        @(negedge clk);
        chk(8'h55, 1, 0, 1);
        swd = 3'h7;
        swr = 3'h7;
        run(rwa_pkg::RWA_OP_ADD, rwa_pkg::RWA_SRC_IMM, 8'h01, 0, 3'h1, 0);
        swr = 3'h0;
        chk(8'h56, 0, 1, 1);
    endtask
    task automatic t_ops();
        run(rwa_pkg::RWA_OP_PASS_B, rwa_pkg::RWA_SRC_IMM, 8'h3c, 0, 3'h0, 0);
        run(rwa_pkg::RWA_OP_AND, rwa_pkg::RWA_SRC_IMM, 8'h0f, 0, 3'h4, 0);
        chk(8'h0c, 0, 1, 0);
        run(rwa_pkg::RWA_OP_IOR, rwa_pkg::RWA_SRC_IMM, 8'h30, 0, 3'h4, 0);
        chk(8'h3c, 0, 1, 0);
        run(rwa_pkg::RWA_OP_COM, rwa_pkg::RWA_SRC_IMM, 8'hff, 0, 3'h4, 0);
        chk(8'h00, 0, 1, 1);
        run(rwa_pkg::RWA_OP_INC, rwa_pkg::RWA_SRC_IMM, 8'h7f, 0, 3'h4, 0);
        chk(8'h80, 0, 1, 0);
        run(rwa_pkg::RWA_OP_DEC, rwa_pkg::RWA_SRC_IMM, 8'h01, 0, 3'h4, 0);
        chk(8'h00, 0, 1, 1);
        run(rwa_pkg::RWA_OP_RLF, rwa_pkg::RWA_SRC_IMM, 8'h81, 0, 3'h1, 0);
        chk(8'h02, 1, 1, 1);
        run(rwa_pkg::RWA_OP_RRF, rwa_pkg::RWA_SRC_IMM, 8'h02, 0, 3'h1, 0);
        chk(8'h81, 0, 1, 1);
        run(rwa_pkg::RWA_OP_SWAP, rwa_pkg::RWA_SRC_IMM, 8'ha5, 0, 3'h0, 0);
        chk(8'h5a, 0, 1, 1);
        run(rwa_pkg::RWA_OP_PASS_A, rwa_pkg::RWA_SRC_IMM, 8'h00, 1, 3'h4, 0);
        `CHK(fwd, 8'h5a)
        chk(8'h5a, 0, 1, 0);
        run(rwa_pkg::RWA_OP_CLR, rwa_pkg::RWA_SRC_IMM, 8'h00, 0, 3'h4, 0);
        chk(8'h00, 0, 1, 1);
    endtask
    task automatic t_reset();
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        chk(8'h00, 0, 0, 0);
        `CHK({instr, vld, we, fetch}, {14'h0000, 3'h1})
        rst_b = 1'b1;
        run(rwa_pkg::RWA_OP_PASS_B, rwa_pkg::RWA_SRC_IMM, 8'h77, 0, 3'h7, 0);
        chk(8'h00, 0, 0, 0);
        run(rwa_pkg::RWA_OP_PASS_B, rwa_pkg::RWA_SRC_IMM, 8'h66, 0, 3'h4, 0);
        `CHK({w, z, vld}, {8'h66, 2'h1})
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        t_phase();
        run(rwa_pkg::RWA_OP_CLR, rwa_pkg::RWA_SRC_IMM, 8'h00, 0, 3'h0, 0);
        t_arith();
        t_file();
        t_branch();
        t_status();
        t_ops();
        t_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
